// ==== tsm_map.vh ====
// Purpose: register map, field positions and reset values of the split timer block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: included by the top-level design file and the testbench
`ifndef TSM_MAP_VH
`define TSM_MAP_VH

// ********************
// register offsets
// ********************
`define TSM_OFF_CTRL 12'h410
`define TSM_OFF_MODE 12'h400
`define TSM_OFF_TIMER_STATUS_REGISTER 12'h404
`define TSM_OFF_CNT0 12'h408
`define TSM_OFF_CNT1 12'h40C
`define TSM_OFF_IRQ 12'h420
`define TSM_OFF_MASK 12'h424

// ********************
// control register fields
// ********************
`define TSM_TF1 7
`define TSM_TR1 6
`define TSM_TF0 5
`define TSM_TR0 4
`define TSM_IE1 3
`define TSM_IT1 2
`define TSM_IE0 1
`define TSM_IT0 0
`define TSM_CTRL_RST 8'h00

// ********************
// mode register fields: gate, c/t, m1, m0 per timer; reload value and status register bits
// ********************
`define TSM_MODE_RST 8'h00
`define TSM_M_SPLIT 2'h3
`define TSM_M_FREE16 2'h1
`define TSM_M_RLD8 2'h2
`define TSM_GATE1 7
`define TSM_CT1 6
`define TSM_M1_HI 5
`define TSM_M1_LO 4
`define TSM_GATE0 3
`define TSM_CT0 2
`define TSM_M0_HI 1
`define TSM_M0_LO 0
`define TSM_RLD_VAL 8'h00
`define TSM_SECOND_TOGGLE_OUT_ENABLE 2
`define TSM_T0OE 0
`define TSM_TIMER_STATUS_REGISTER_RST 8'h00

// ********************
// interrupt status bits
// ********************
`define TSM_EV_TF0 0
`define TSM_EV_IE0 1
`define TSM_EV_TF1 2
`define TSM_EV_IE1 3
`define TSM_EV_W 4

`endif

// ==== tsm_cnt8.v ====
// Purpose: one 8-bit counter with enable and load
// Assumes: synchronous increment on core_clk
// Notes: overflow is a one-cycle pulse on wrap from FF to 00
`timescale 1ns/1ps
module tsm_cnt8 #(
  parameter W = 8
) (
  input wire core_clk,
  input wire arst_n,
  input wire inc,
  input wire load,
  input wire [W-1:0] load_val,
  output reg [W-1:0] cnt_q,
  output wire ovf
);
  // no load term: the parent reloads on this pulse, a load term would close a loop
  assign ovf = inc && (&cnt_q);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= load_val;
    end else if (inc) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // tsm_cnt8

// ==== tsm_edge.v ====
// Purpose: external interrupt pin edge/level detector
// Assumes: pin is synchronous to core_clk
// Notes: hit pulses once per falling edge, or every cycle low in level mode
`timescale 1ns/1ps
module tsm_edge (
  input wire core_clk,
  input wire arst_n,
  input wire pin,
  input wire level_mode,
  output wire hit
);
  reg pin_q;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin;
    end
  end

  // edge mode sees only high-to-low; level mode re-asserts while low
  assign hit = level_mode ? !pin : (pin_q && !pin);
endmodule // tsm_edge

// ==== tsm_top.v ====
// Purpose: split-mode control of two general timers with shared run/flag register
// Assumes: AHB-Lite slave, single word transfers, one clock, inputs synchronous
// Notes: prescaler and count pins arrive as one-cycle tick inputs
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "tsm_map.vh"

module tsm_top (
  input wire core_clk,
  input wire arst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire presc_tick,
  input wire count_pin0,
  input wire count_pin1,
  input wire ext_interrupt_pin_zero,
  input wire ext_interrupt_pin_one,
  input wire vector_ack0,
  input wire vector_ack1,
  input wire ext_ack0,
  input wire ext_ack1,
  output wire first_timer_ovf,
  output wire second_timer_ovf,
  output wire ext_req0,
  output wire ext_req1,
  output wire irq
);
  // ********************
  // bus slave
  // ********************
  reg wr_pend_q;
  reg [11:0] wr_addr_q;
  reg [7:0] timer_run_and_flag_control_q;
  reg [7:0] mode_q;
  reg [7:0] timer_status_register_q;
  reg [`TSM_EV_W-1:0] irq_stat_q;
  reg [`TSM_EV_W-1:0] irq_mask_q;
  wire acc = hsel && hready && htrans[1];
  wire rd_acc = acc && !hwrite;
  wire [11:0] a = haddr[11:0];
  wire [7:0] wd = hwdata[7:0];

  // one decoder for every write strobe, so all of them fire in the data phase
  function wr_hit;
    input pend;
    input [11:0] qaddr;
    input [11:0] off;
    begin
      wr_hit = pend && (qaddr == off);
    end
  endfunction

  wire wr_ctrl = wr_hit(wr_pend_q, wr_addr_q, `TSM_OFF_CTRL);
  wire wr_mode = wr_hit(wr_pend_q, wr_addr_q, `TSM_OFF_MODE);
  wire wr_timer_status_register = wr_hit(wr_pend_q, wr_addr_q, `TSM_OFF_TIMER_STATUS_REGISTER);
  wire wr_cnt0 = wr_hit(wr_pend_q, wr_addr_q, `TSM_OFF_CNT0);
  wire wr_cnt1 = wr_hit(wr_pend_q, wr_addr_q, `TSM_OFF_CNT1);
  wire wr_mask = wr_hit(wr_pend_q, wr_addr_q, `TSM_OFF_MASK);
  wire rd_irq = rd_acc && (a == `TSM_OFF_IRQ);

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= acc && hwrite;
      wr_addr_q <= a;
    end
  end

  // ********************
  // mode decode
  // ********************
  wire gate0 = mode_q[`TSM_GATE0];
  wire ct0 = mode_q[`TSM_CT0];
  wire [1:0] m0 = mode_q[`TSM_M0_HI:`TSM_M0_LO];
  wire gate1 = mode_q[`TSM_GATE1];
  wire ct1 = mode_q[`TSM_CT1];
  wire [1:0] m1 = mode_q[`TSM_M1_HI:`TSM_M1_LO];
  wire split0 = (m0 == `TSM_M_SPLIT);
  wire split1 = (m1 == `TSM_M_SPLIT);
  wire tr0 = timer_run_and_flag_control_q[`TSM_TR0];
  wire tr1 = timer_run_and_flag_control_q[`TSM_TR1];

  function run_ok;
    input gate;
    input run;
    input pin;
    begin
      run_ok = run && (!gate || pin);
    end
  endfunction

  function src_tick;
    input ct;
    input presc;
    input cpin;
    begin
      src_tick = ct ? cpin : presc;
    end
  endfunction

  // mode 2 overflows on the low byte, every other mode on the high byte
  function ovf_sel;
    input [1:0] mode;
    input ovl;
    input ovh;
    begin
      ovf_sel = (mode == `TSM_M_RLD8) ? ovl : ovh;
    end
  endfunction

  // only the free-running mode and first-timer split mode roll past the top without a reload
  function reload_hit;
    input [1:0] mode;
    input ovl;
    input ovh;
    begin
      reload_hit = (mode != `TSM_M_FREE16) && ovf_sel(mode, ovl, ovh);
    end
  endfunction

  wire en0 = run_ok(gate0, tr0, ext_interrupt_pin_zero);
  wire inc0 = en0 && src_tick(ct0, presc_tick, count_pin0);
  // second timer stops only in its own split mode
  wire en1 = run_ok(gate1, tr1, ext_interrupt_pin_one) && !split1;
  wire inc1 = en1 && src_tick(ct1, presc_tick, count_pin1);
  // high half ignores gate and pin, counts the prescaled clock
  wire inc0h_split = tr1 && presc_tick;

  // ********************
  // counters
  // ********************
  wire [7:0] c0l;
  wire [7:0] c0h;
  wire [7:0] c1l;
  wire [7:0] c1h;
  wire ov0l;
  wire ov0h;
  wire ov1l;
  wire ov1h;
  wire inc0l_w = inc0;
  // in split mode the low carry no longer feeds the high byte
  wire inc0h_w = split0 ? inc0h_split : (m0 != `TSM_M_RLD8) && ov0l;
  wire inc1h_w = (m1 != `TSM_M_RLD8) && ov1l;
  // reload is to zero: the reload value registers are not part of this block
  wire ld0l = wr_cnt0 || (!split0 && reload_hit(m0, ov0l, ov0h));
  wire ld1l = wr_cnt1 || reload_hit(m1, ov1l, ov1h);
  // a software write wins over a reload that falls in the same cycle
  wire [7:0] ld0l_val = wr_cnt0 ? hwdata[7:0] : `TSM_RLD_VAL;
  wire [7:0] ld1l_val = wr_cnt1 ? hwdata[7:0] : `TSM_RLD_VAL;

  tsm_cnt8 #(.W(8)) u_c0l (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inc(inc0l_w),
    .load(ld0l),
    .load_val(ld0l_val),
    .cnt_q(c0l),
    .ovf(ov0l)
  );
  tsm_cnt8 #(.W(8)) u_c0h (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inc(inc0h_w),
    .load(wr_cnt0),
    .load_val(hwdata[15:8]),
    .cnt_q(c0h),
    .ovf(ov0h)
  );
  tsm_cnt8 #(.W(8)) u_c1l (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inc(inc1),
    .load(ld1l),
    .load_val(ld1l_val),
    .cnt_q(c1l),
    .ovf(ov1l)
  );
  tsm_cnt8 #(.W(8)) u_c1h (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inc(inc1h_w),
    .load(wr_cnt1),
    .load_val(hwdata[15:8]),
    .cnt_q(c1h),
    .ovf(ov1h)
  );

  // overflow events: mode 2 and first-timer split mode use the low byte, others the high byte
  // a write that lands on an overflow still lets the flag set: losing it is worse
  wire t0_ovf = split0 ? ov0l : ovf_sel(m0, ov0l, ov0h);
  wire t1_own_ovf = ovf_sel(m1, ov1l, ov1h);
  wire t1_ovf = split0 ? ov0h : t1_own_ovf;
  assign first_timer_ovf = t0_ovf;
  assign second_timer_ovf = t1_own_ovf; // baud source stays usable

  // ********************
  // external interrupt inputs
  // ********************
  wire hit0;
  wire hit1;
  tsm_edge u_e0 (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(ext_interrupt_pin_zero),
    .level_mode(!timer_run_and_flag_control_q[`TSM_IT0]),
    .hit(hit0)
  );
  tsm_edge u_e1 (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(ext_interrupt_pin_one),
    .level_mode(!timer_run_and_flag_control_q[`TSM_IT1]),
    .hit(hit1)
  );

  // ********************
  // control register
  // ********************
  wire set_tf0 = t0_ovf && !timer_status_register_q[`TSM_T0OE];
  // while first timer is split its high half owns this flag
  wire set_tf1 = t1_ovf && !timer_status_register_q[`TSM_SECOND_TOGGLE_OUT_ENABLE];
  reg [7:0] ctrl_d;

  always @* begin
    ctrl_d = timer_run_and_flag_control_q;
    if (wr_ctrl) begin
      ctrl_d = wd;
    end
    if (vector_ack0) begin
      ctrl_d[`TSM_TF0] = 1'b0;
    end
    if (vector_ack1) begin
      ctrl_d[`TSM_TF1] = 1'b0;
    end
    if (ext_ack0) begin
      ctrl_d[`TSM_IE0] = 1'b0;
    end
    if (ext_ack1) begin
      ctrl_d[`TSM_IE1] = 1'b0;
    end
    // hardware sets win over any clear in the same cycle
    if (set_tf0) begin
      ctrl_d[`TSM_TF0] = 1'b1;
    end
    if (set_tf1) begin
      ctrl_d[`TSM_TF1] = 1'b1;
    end
    if (hit0) begin
      ctrl_d[`TSM_IE0] = 1'b1;
    end
    if (hit1) begin
      ctrl_d[`TSM_IE1] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_run_and_flag_control_q <= `TSM_CTRL_RST;
      mode_q <= `TSM_MODE_RST;
      timer_status_register_q <= `TSM_TIMER_STATUS_REGISTER_RST;
    end else begin
      timer_run_and_flag_control_q <= ctrl_d;
      if (wr_mode) begin
        mode_q <= wd;
      end
      if (wr_timer_status_register) begin
        timer_status_register_q <= wd;
      end
    end
  end

  // request is the edge flag in both modes; level mode re-sets it while the pin is low
  assign ext_req0 = timer_run_and_flag_control_q[`TSM_IE0];
  assign ext_req1 = timer_run_and_flag_control_q[`TSM_IE1];

  // ********************
  // interrupt status and mask
  // ********************
  wire [`TSM_EV_W-1:0] ev = {hit1, set_tf1, hit0, set_tf0};

  // read-to-clear; an event in the read cycle survives
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= {`TSM_EV_W{1'b0}};
      irq_mask_q <= {`TSM_EV_W{1'b0}};
    end else begin
      irq_stat_q <= (rd_irq ? {`TSM_EV_W{1'b0}} : irq_stat_q) | ev;
      if (wr_mask) begin
        irq_mask_q <= hwdata[`TSM_EV_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ********************
  // read data
  // ********************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_acc) begin
      case (a)
        `TSM_OFF_CTRL: hrdata <= {24'h000000, timer_run_and_flag_control_q};
        `TSM_OFF_MODE: hrdata <= {24'h000000, mode_q};
        `TSM_OFF_TIMER_STATUS_REGISTER: hrdata <= {24'h000000, timer_status_register_q};
        `TSM_OFF_CNT0: hrdata <= {16'h0000, c0h, c0l};
        `TSM_OFF_CNT1: hrdata <= {16'h0000, c1h, c1l};
        `TSM_OFF_IRQ: hrdata <= {28'h0000000, irq_stat_q};
        `TSM_OFF_MASK: hrdata <= {28'h0000000, irq_mask_q};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  wire unused_ok = |{hsize, haddr[31:12], hwdata[31:16]};
endmodule // tsm_top

// ==== tsm_chk.sv ====
// Purpose: port-level checks of the split timer block
// Assumes: one clock, async active-low reset
// Notes: bound to tsm_top below
`timescale 1ns/1ps
module tsm_chk (
  input wire core_clk,
  input wire arst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire presc_tick,
  input wire count_pin0,
  input wire count_pin1,
  input wire ext_interrupt_pin_zero,
  input wire ext_interrupt_pin_one,
  input wire ext_ack0,
  input wire ext_ack1,
  input wire first_timer_ovf,
  input wire second_timer_ovf,
  input wire ext_req0,
  input wire ext_req1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // pin held high with no bus traffic, so no set can compete with the clear
  sequence s_quiet0;
    (ext_interrupt_pin_zero && !htrans[1]) [*3];
  endsequence
  sequence s_quiet1;
    (ext_interrupt_pin_one && !htrans[1]) [*3];
  endsequence
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout dropped");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_edge_zero: assert property ($fell(ext_interrupt_pin_zero) |-> ##[1:3] ext_req0)
    else $error("pin zero fall not flagged");
  chk_edge_one: assert property ($fell(ext_interrupt_pin_one) |-> ##[1:3] ext_req1)
    else $error("pin one fall not flagged");
  chk_ack_zero: assert property (s_quiet0 ##0 ext_ack0 |=> !ext_req0)
    else $error("edge flag zero not cleared");
  chk_ack_one: assert property (s_quiet1 ##0 ext_ack1 |=> !ext_req1)
    else $error("edge flag one not cleared");
  chk_ovf0_cause: assert property (first_timer_ovf |-> presc_tick || count_pin0)
    else $error("first overflow without count");
  chk_ovf1_cause: assert property (second_timer_ovf |-> presc_tick || count_pin1)
    else $error("second overflow without count");
  chk_rdata_holds: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
    |-> $stable(hrdata))
    else $error("hrdata changed without read");
endmodule // tsm_chk

bind tsm_top tsm_chk i_tsm_chk (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .presc_tick(presc_tick),
  .count_pin0(count_pin0), .count_pin1(count_pin1),
  .ext_interrupt_pin_zero(ext_interrupt_pin_zero),
  .ext_interrupt_pin_one(ext_interrupt_pin_one), .ext_ack0(ext_ack0),
  .ext_ack1(ext_ack1), .first_timer_ovf(first_timer_ovf),
  .second_timer_ovf(second_timer_ovf), .ext_req0(ext_req0), .ext_req1(ext_req1));

// ==== tsm_pin_model.sv ====
// Purpose: interrupt pins and prescaled tick seen by the block
// Assumes: pins change just after a clock edge
// Notes: pins idle high like a pulled-up line
`timescale 1ns/1ps
module tsm_pin_model (
  input wire core_clk,
  input wire arst_n,
  input wire tick_req,
  input wire [1:0] pin_lvl,
  output logic presc_tick,
  output logic pin0,
  output logic pin1
);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_tick <= 1'b0;
      pin0 <= 1'b1;
      pin1 <= 1'b1;
    end else begin
      presc_tick <= tick_req;
      pin0 <= pin_lvl[0];
      pin1 <= pin_lvl[1];
    end
  end
endmodule // tsm_pin_model

// ==== tb_timer_split_mode_control.sv ====
// Purpose: register-level tests of the split timer block
// Assumes: zero-wait slave, one tick per prescaler pulse
// Notes: count pins stay low, only timer mode is exercised
`timescale 1ns/1ps
`include "tsm_map.vh"
module tb_timer_split_mode_control;
  logic core_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, tick_req = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, pin_lvl = 2'h3, ext_ack = 0, vack = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, presc_tick, pin0, pin1, irq;
  logic ftov, stov;
  logic [1:0] ereq;
  int num_errors = 0, total_checks = 0;
  int n_ov0 = 0, n_ov1 = 0;
  always #50 core_clk = ~core_clk;
  tsm_pin_model i_tsm_pin_model (.core_clk(core_clk), .arst_n(arst_n), .tick_req(tick_req),
    .pin_lvl(pin_lvl), .presc_tick(presc_tick), .pin0(pin0), .pin1(pin1));
  tsm_top i_tsm_top (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .presc_tick(presc_tick),
    .count_pin0(1'b0), .count_pin1(1'b0), .ext_interrupt_pin_zero(pin0),
    .ext_interrupt_pin_one(pin1), .vector_ack0(vack[0]), .vector_ack1(vack[1]),
    .ext_ack0(ext_ack[0]), .ext_ack1(ext_ack[1]), .first_timer_ovf(ftov),
    .second_timer_ovf(stov), .ext_req0(ereq[0]), .ext_req1(ereq[1]), .irq(irq));
  // overflow pulses counted at the edge on which the design acts on them
  always @(posedge core_clk) begin
    if (ftov === 1'b1) n_ov0 <= n_ov0 + 1;
    if (stov === 1'b1) n_ov1 <= n_ov1 + 1;
  end
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // master waits for hready in both phases, no fixed latency assumed
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do cyc(1); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do cyc(1); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t bit %b want %b", $time, got, exp);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task tick;
    tick_req <= 1'b1;
    cyc(1);
    tick_req <= 1'b0;
    cyc(3);
  endtask
  task ext_case(input int n);
    bus(1'b1, `TSM_OFF_CTRL, 32'h1 << (2 * n));
    pin_lvl[n] <= 1'b0;
    cyc(2);
    pin_lvl[n] <= 1'b1;
    cyc(3);
    rd(`TSM_OFF_CTRL, 32'h3 << (2 * n));
    chk_bit(ereq[n], 1'b1);
    ext_ack[n] <= 1'b1;
    cyc(1);
    ext_ack[n] <= 1'b0;
    cyc(2);
    rd(`TSM_OFF_CTRL, 32'h1 << (2 * n));
    bus(1'b1, `TSM_OFF_CTRL, 32'h0);
    pin_lvl[n] <= 1'b0;
    cyc(3);
    ext_ack[n] <= 1'b1;
    cyc(1);
    ext_ack[n] <= 1'b0;
    cyc(1);
    rd(`TSM_OFF_CTRL, 32'h2 << (2 * n));
    pin_lvl[n] <= 1'b1;
    cyc(3);
    ext_ack[n] <= 1'b1;
    cyc(1);
    ext_ack[n] <= 1'b0;
    cyc(2);
    rd(`TSM_OFF_CTRL, 32'h0);
    chk_bit(ereq[n], 1'b0);
  endtask
  task vector(input int n);
    vack[n] <= 1'b1;
    cyc(1);
    vack[n] <= 1'b0;
    cyc(1);
  endtask
  initial begin
    cyc(5);
    arst_n <= 1'b1;
    cyc(1);
    rd(`TSM_OFF_CTRL, 32'h0);
    rd(`TSM_OFF_MODE, 32'h0);
    rd(`TSM_OFF_TIMER_STATUS_REGISTER, 32'h0);
    bus(1'b1, 12'h500, 32'hFF);
    rd(12'h500, 32'h0);
    ext_case(0);
    ext_case(1);
    bus(1'b0, `TSM_OFF_IRQ, 32'h0);
    bus(1'b1, `TSM_OFF_MASK, 32'h0);
    bus(1'b1, `TSM_OFF_MODE, 32'h03);
    bus(1'b1, `TSM_OFF_CNT0, 32'hFEFF);
    bus(1'b1, `TSM_OFF_CTRL, 32'h50);
    tick;
    rd(`TSM_OFF_CNT0, 32'hFF00);
    rd(`TSM_OFF_CTRL, 32'h70);
    tick;
    rd(`TSM_OFF_CNT0, 32'h0001);
    rd(`TSM_OFF_CTRL, 32'hF0);
    rd(`TSM_OFF_CNT1, 32'h2);
    chk_bit(irq, 1'b0);
    bus(1'b1, `TSM_OFF_MASK, 32'h1);
    cyc(1);
    chk_bit(irq, 1'b1);
    vector(0);
    rd(`TSM_OFF_CTRL, 32'hD0);
    vector(1);
    rd(`TSM_OFF_CTRL, 32'h50);
    rd(`TSM_OFF_IRQ, 32'h5);
    cyc(1);
    chk_bit(irq, 1'b0);
    bus(1'b1, `TSM_OFF_MODE, 32'h0B);
    pin_lvl[0] <= 1'b0;
    tick;
    rd(`TSM_OFF_CNT0, 32'h0101);
    pin_lvl[0] <= 1'b1;
    tick;
    rd(`TSM_OFF_CNT0, 32'h0202);
    bus(1'b1, `TSM_OFF_MODE, 32'h33);
    tick;
    rd(`TSM_OFF_CNT1, 32'h4);
    bus(1'b1, `TSM_OFF_TIMER_STATUS_REGISTER, 32'h1);
    bus(1'b1, `TSM_OFF_CTRL, 32'h50);
    bus(1'b1, `TSM_OFF_CNT0, 32'h00FF);
    tick;
    rd(`TSM_OFF_CTRL, 32'h50);
    chk(n_ov0, 32'h00000002);
    chk(n_ov1, 32'h00000000);
    summarize;
  end
  initial begin
    cyc(5000);
    num_errors++;
    summarize;
  end
endmodule // tb_timer_split_mode_control
